// file: pkg/fpexc_pkg.sv
/*
  Constants, opcodes and states of the floating-point exception and
  operand-screening unit. Assumes a 200 MHz core clock and an APB
  register port with 32-bit data.
*/
`default_nettype none
package fpexc_pkg;
  // ***************************************
  // register map
  // ***************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam int CTRL_DEFER = 0;
  localparam int CTRL_ALIGN_EN = 1;
  localparam int CTRL_VVEC_LSB = 8;
  localparam int STAT_PEND = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_VEC_LSB = 8;
  localparam int STAT_COND_LSB = 16;
  localparam logic [7:0] CTRL_VVEC_RST = 8'h10;

  // ***************************************
  // fault vectors
  // ***************************************
  localparam logic [7:0] VEC_DEV_UNAVAIL = 8'h07;
  localparam logic [7:0] VEC_SEG_ABSENT = 8'h0b;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_FP_ERROR = 8'h10;
  localparam logic [7:0] VEC_ALIGN = 8'h11;

  // ***************************************
  // operand exponents (biased, 15 bits), user privilege level and indefinite codes
  // ***************************************
  localparam logic [14:0] EXP_BIAS = 15'h3fff;
  localparam logic [14:0] EXP_TAN_LIMIT = 15'h403e;
  localparam logic [1:0] PRIV_USER = 2'h3;
  localparam logic [1:0] INDEF_REAL = 2'h1;
  localparam logic [1:0] INDEF_INT = 2'h2;
  localparam logic [1:0] INDEF_DEC = 2'h3;

  typedef enum logic [4:0] {
    OP_ARITH = 5'b00000, OP_DIVIDE = 5'b00001, OP_SQRT = 5'b00010,
    OP_PREM = 5'b00011, OP_IEEE_REM = 5'b00100, OP_SCALE = 5'b00101,
    OP_UCOM = 5'b00110, OP_UCOM_POP = 5'b00111, OP_UCOM_POP2 = 5'b01000,
    OP_TAN = 5'b01001, OP_SINE = 5'b01010, OP_COSINE = 5'b01011,
    OP_SINCOS = 5'b01100, OP_ATAN = 5'b01101, OP_EXP2M1 = 5'b01110,
    OP_ENV_LOAD = 5'b01111, OP_STATE_SAVE = 5'b10000, OP_XSAVE = 5'b10001,
    OP_STATE_RESTORE = 5'b10010, OP_XRESTORE = 5'b10011,
    OP_TO_INT = 5'b10100, OP_TO_DEC = 5'b10101
  } fpexc_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PEND = 2'b01, ST_SIGNAL = 2'b10
  } fpexc_st_e;
endpackage : fpexc_pkg
`default_nettype wire

// file: rtl/fpexc_unit.sv
/*
  Exception signalling and operand screening for a floating-point unit.
  Assumes the core presents one instruction per issue pulse with its
  operand classification, reports completion separately, and that all
  inputs are synchronous to clock_i.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module fpexc_unit (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic issue_i,
  input wire fpexc_pkg::fpexc_op_e op_i,
  input wire logic denormal_i,
  input wire logic misaligned_i,
  input wire logic stack_part_i,
  input wire logic [1:0] cpl_i,
  input wire logic v86_i,
  input wire logic dev_unavail_i,
  input wire logic seg_overrun_i,
  input wire logic beyond_limit_i,
  input wire logic env_first_ok_i,
  input wire logic env_last_ok_i,
  input wire logic stack_overflow_i,
  input wire logic invalid_masked_i,
  input wire logic snan_i,
  input wire logic underflow_i,
  input wire logic inexact_i,
  input wire logic uflow_loss_i,
  input wire logic [2:0] quotient_i,
  input wire logic cmp_less_i,
  input wire logic cmp_equal_i,
  input wire logic cmp_unord_i,
  input wire logic [14:0] top_exp_i,
  input wire logic top_zero_i,
  input wire logic [14:0] next_exp_i,
  input wire logic next_zero_i,
  input wire logic complete_i,
  input wire logic unmasked_exc_i,
  input wire logic handled_i,
  output logic fp_error_out_o,
  output logic done_o,
  output logic fault_o,
  output logic [7:0] fault_vec_o,
  output logic abort_o,
  output logic normalize_o,
  output logic invalid_o,
  output logic underflow_o,
  output logic precision_o,
  output logic range_err_o,
  output logic scale_keep_o,
  output logic round_nearest_o,
  output logic env_commit_o,
  output logic [1:0] indef_o,
  output logic cond_we_o,
  output logic [3:0] cond_o
);
  import fpexc_pkg::*;

  // ***************************************
  // decode helpers
  // ***************************************
  // ops that normalize a denormal operand instead of trapping on it
  function automatic logic is_denorm_op(input fpexc_op_e op);
    is_denorm_op = (op == OP_DIVIDE) || (op == OP_SQRT) || (op == OP_PREM) ||
                   (op == OP_IEEE_REM) || (op == OP_TO_INT) || (op == OP_TO_DEC);
  endfunction : is_denorm_op

  // ops whose stack frame is exempt from the alignment trap
  function automatic logic is_save_restore(input fpexc_op_e op);
    is_save_restore = (op == OP_STATE_SAVE) || (op == OP_XSAVE) ||
                      (op == OP_STATE_RESTORE) || (op == OP_XRESTORE);
  endfunction : is_save_restore

  // the three unordered compare forms
  function automatic logic is_ucom(input fpexc_op_e op);
    is_ucom = (op == OP_UCOM) || (op == OP_UCOM_POP) || (op == OP_UCOM_POP2);
  endfunction : is_ucom

  // ***************************************
  // state and software registers
  // ***************************************
  fpexc_st_e state;
  fpexc_st_e next_state;
  // software-visible control fields
  logic defer_mode;
  logic align_en;
  logic [7:0] v86_vec;
  // fault history seen by software
  logic [7:0] last_vec;
  logic [15:0] fault_count;
  logic sw_clear;
  logic exc_set;
  logic ac_hit;
  logic top_below_one;
  logic next_in_unit;

  // next values of the registered result pulses
  logic next_done, next_fault, next_abort, next_norm, next_inv, next_uf;
  logic next_prec, next_rerr, next_keep, next_rn, next_commit, next_cwe;
  logic [7:0] next_vec;
  logic [1:0] next_indef;
  logic [3:0] next_cond;

  // a status write of the pending bit clears it, on the pready edge too
  assign sw_clear = psel_i && penable_i && pready_o && pwrite_i &&
                    (paddr_i == {28'h000_0000, ADDR_STATUS}) && pwdata_i[STAT_PEND];
  assign exc_set = complete_i && unmasked_exc_i;
  // user-level misaligned data traps; save/restore stack frames are exempt
  assign ac_hit = align_en && misaligned_i && (cpl_i == PRIV_USER) &&
                  !(stack_part_i && is_save_restore(op_i));
  // exponents below the bias mean a magnitude below one
  assign top_below_one = top_exp_i < EXP_BIAS;
  assign next_in_unit = !next_zero_i && (next_exp_i < EXP_BIAS);

  // ***************************************
  // pending-error tracking
  // ***************************************
  // a new exception wins over a clear in the same cycle
  // immediate mode raises the pin on the completing edge; deferred mode
  // parks in pending and raises it when the next instruction is issued,
  // so the handler sees the error before that instruction can run
  always_comb begin
    next_state = state;
    if (exc_set) begin
      next_state = defer_mode ? ST_PEND : ST_SIGNAL;
    end else if (handled_i || sw_clear) begin
      next_state = ST_IDLE;
    end else if (state == ST_PEND && issue_i) begin
      next_state = ST_SIGNAL;
    end
  end

  // pin is taken from the next state so it rises together with the state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      fp_error_out_o <= 1'b0;
    end else begin
      state <= next_state;
      fp_error_out_o <= (next_state == ST_SIGNAL);
    end
  end

  // ***************************************
  // per-instruction screening
  // ***************************************
  // fault order: pending error, overrun abort, device unavailable, then address checks
  // a pending error refuses every instruction, so nothing below it can
  // change architectural state until the handler has cleared it
  // overrun is an abort, never a fault: vector nine does not exist here
  always_comb begin
    next_done = 1'b0;
    next_fault = 1'b0;
    next_abort = 1'b0;
    next_norm = 1'b0;
    next_inv = 1'b0;
    next_uf = 1'b0;
    next_prec = 1'b0;
    next_rerr = 1'b0;
    next_keep = 1'b0;
    next_rn = 1'b0;
    next_commit = 1'b0;
    next_cwe = 1'b0;
    next_vec = 8'h00;
    next_indef = 2'h0;
    next_cond = 4'h0;
    if (issue_i) begin
      if (state != ST_IDLE) begin
        next_fault = 1'b1;
        next_vec = v86_i ? v86_vec : VEC_FP_ERROR;
      end else if (seg_overrun_i) begin
        next_abort = 1'b1;
      end else if (dev_unavail_i) begin
        next_fault = 1'b1;
        next_vec = VEC_DEV_UNAVAIL;
      end else if (beyond_limit_i) begin
        next_fault = 1'b1;
        next_vec = VEC_GEN_PROT;
      end else if (ac_hit) begin
        next_fault = 1'b1;
        next_vec = VEC_ALIGN;
      end else if (op_i == OP_ENV_LOAD && !(env_first_ok_i && env_last_ok_i)) begin
        next_fault = 1'b1;
        next_vec = VEC_SEG_ABSENT;
      end else begin
        // clean issue: report completion and the side effects of the op
        next_done = 1'b1;
        next_commit = (op_i == OP_ENV_LOAD);
        next_norm = denormal_i && is_denorm_op(op_i);
        next_uf = underflow_i && is_denorm_op(op_i);
        if (stack_overflow_i && invalid_masked_i) begin
          // result type picks which indefinite is written
          case (op_i)
            OP_TO_INT: next_indef = INDEF_INT;
            OP_TO_DEC: next_indef = INDEF_DEC;
            default: next_indef = INDEF_REAL;
          endcase
        end
        // per-op flags; ops not listed get none of the flags set below
        case (op_i)
          OP_PREM, OP_IEEE_REM: begin
            next_rn = (op_i == OP_IEEE_REM);
            next_cwe = 1'b1;
            // {c3,c2,c1,c0}: c0=q2, c3=q1, c1=q0
            next_cond = {quotient_i[1], 1'b0, quotient_i[0], quotient_i[2]};
          end
          OP_UCOM, OP_UCOM_POP, OP_UCOM_POP2: begin
            next_cwe = 1'b1;
            next_inv = snan_i; // quiet NaNs compare unordered without trapping
            next_cond = cmp_unord_i ? 4'b1101 :
                        {cmp_equal_i, 2'b00, cmp_less_i};
          end
          OP_SCALE: begin
            next_keep = next_in_unit;
            next_prec = inexact_i || uflow_loss_i;
          end
          OP_TAN: begin
            next_rerr = !(top_exp_i < EXP_TAN_LIMIT);
          end
          OP_EXP2M1: begin
            next_rerr = !(top_zero_i || top_below_one);
          end
          OP_SINE, OP_COSINE, OP_SINCOS: begin
            next_rerr = !(top_exp_i < EXP_TAN_LIMIT);
          end
          OP_ATAN: begin
            next_rerr = 1'b0;
          end
          default: begin
            next_rerr = 1'b0;
          end
        endcase
        // unordered compare of quiet operands never flags invalid
        if (is_ucom(op_i) && cmp_unord_i && !snan_i) begin
          next_inv = 1'b0;
        end
      end
    end
  end

  // registered result pulses, one cycle after issue
  // cond_o is held between writes so software can still read it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      fault_o <= 1'b0;
      fault_vec_o <= 8'h00;
      abort_o <= 1'b0;
      normalize_o <= 1'b0;
      invalid_o <= 1'b0;
      underflow_o <= 1'b0;
      precision_o <= 1'b0;
      range_err_o <= 1'b0;
      scale_keep_o <= 1'b0;
      round_nearest_o <= 1'b0;
      env_commit_o <= 1'b0;
      indef_o <= 2'h0;
      cond_we_o <= 1'b0;
      cond_o <= 4'h0;
    end else begin
      done_o <= next_done;
      fault_o <= next_fault;
      fault_vec_o <= next_vec;
      abort_o <= next_abort;
      normalize_o <= next_norm;
      invalid_o <= next_inv;
      underflow_o <= next_uf;
      precision_o <= next_prec;
      range_err_o <= next_rerr;
      scale_keep_o <= next_keep;
      round_nearest_o <= next_rn;
      env_commit_o <= next_commit;
      indef_o <= next_indef;
      cond_we_o <= next_cwe;
      if (next_cwe) begin
        cond_o <= next_cond;
      end
    end
  end

  // ***************************************
  // fault history
  // ***************************************
  // counts faults only; aborts and clean completions leave it alone
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_vec <= 8'h00;
      fault_count <= 16'h0000;
    end else if (next_fault) begin
      last_vec <= next_vec;
      fault_count <= fault_count + 16'h0001; // wraps silently
    end
  end

  // ***************************************
  // apb slave
  // ***************************************
  // one wait state: pready rises in the second access cycle
  // unmapped offsets and any high address bit answer with an error and
  // read as zero; the count register ignores writes without error
  // prdata is zero outside the answer cycle so a stale word never leaks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_o) begin
        case (paddr_i[3:0])
          ADDR_CTRL: prdata_o <= {16'h0000, v86_vec, 6'h00, align_en, defer_mode};
          ADDR_STATUS: prdata_o <= {12'h000, cond_o, last_vec, 6'h00,
                                    fp_error_out_o, (state != ST_IDLE)};
          ADDR_COUNT: prdata_o <= {16'h0000, fault_count};
          default: pslverr_o <= 1'b1;
        endcase
        if (paddr_i[31:4] != 28'h000_0000) begin
          pslverr_o <= 1'b1;
          prdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  // control register; a write lands at the edge where the master samples
  // pready high, so it never takes effect before the transfer completes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      defer_mode <= 1'b0;
      align_en <= 1'b0;
      v86_vec <= CTRL_VVEC_RST;
    end else if (psel_i && penable_i && pready_o && pwrite_i &&
                 paddr_i == {28'h000_0000, ADDR_CTRL}) begin
      defer_mode <= pwdata_i[CTRL_DEFER];
      align_en <= pwdata_i[CTRL_ALIGN_EN];
      v86_vec <= pwdata_i[CTRL_VVEC_LSB +: 8];
    end
  end
endmodule : fpexc_unit
`default_nettype wire

// file: verif/fpexc_irq_ctrl.sv
/*
  interrupt controller model: turns the error output level into the
  maskable interrupt request LAT cycles later. assumes the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fpexc_irq_ctrl #(
  parameter int LAT = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic fp_error_out_i,
  output logic maskable_interrupt_in_o
);
  logic [LAT-1:0] dly;
  // level follows the pin; a larger LAT models a slow controller
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly <= '0;
    end else begin
      dly <= {dly[LAT-2:0], fp_error_out_i};
    end
  end
  assign maskable_interrupt_in_o = dly[LAT-1];
endmodule : fpexc_irq_ctrl
`default_nettype wire

// file: verif/fpexc_unit_properties.sv
/*
  checker of answers, fault vectors and error pin timing.
  assumes binding into fpexc_unit, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module fpexc_unit_properties (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic issue_i,
  input wire fpexc_pkg::fpexc_op_e op_i,
  input wire logic denormal_i,
  input wire logic misaligned_i,
  input wire logic v86_i,
  input wire logic dev_unavail_i,
  input wire logic seg_overrun_i,
  input wire logic beyond_limit_i,
  input wire logic env_first_ok_i,
  input wire logic env_last_ok_i,
  input wire logic complete_i,
  input wire logic unmasked_exc_i,
  input wire logic handled_i,
  input wire logic fp_error_out_o,
  input wire logic done_o,
  input wire logic fault_o,
  input wire logic [7:0] fault_vec_o,
  input wire logic abort_o,
  input wire logic normalize_o,
  input wire logic env_commit_o
);
  import fpexc_pkg::*;
  logic pend_q, defer_q, wr, clean;
  // *****************
  // mirror state
  // *****************
  // apb write lands at the edge where pready is seen
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  assign clean = issue_i && !pend_q && !seg_overrun_i && !dev_unavail_i && !beyond_limit_i
    && !misaligned_i;
  // pending and defer copies; a new error beats a clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
      defer_q <= 1'b0;
    end else begin
      pend_q <= (complete_i && unmasked_exc_i) || (pend_q && !handled_i
        && !(wr && paddr_i == {28'h000_0000, ADDR_STATUS} && pwdata_i[STAT_PEND]));
      if (wr && paddr_i == {28'h000_0000, ADDR_CTRL}) begin
        defer_q <= pwdata_i[CTRL_DEFER];
      end
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // *****************
  // properties
  // *****************
  property p_one_answer; issue_i |=> $onehot({done_o, fault_o, abort_o}); endproperty
  a_one_answer: assert property (p_one_answer) else $error("not one answer");
  property p_pend; issue_i && pend_q && !v86_i |=> fault_o && fault_vec_o == VEC_FP_ERROR;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not faulted");
  property p_overrun; issue_i && !pend_q && seg_overrun_i |=> abort_o && !fault_o; endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not aborted");
  property p_no_vec9; fault_o |-> fault_vec_o != 8'h09; endproperty
  a_no_vec9: assert property (p_no_vec9) else $error("vector nine seen");
  property p_dev; issue_i && !pend_q && !seg_overrun_i && dev_unavail_i |=> fault_o
    && fault_vec_o == VEC_DEV_UNAVAIL; endproperty
  a_dev: assert property (p_dev) else $error("bad unavailable vector");
  property p_gp; issue_i && !pend_q && !seg_overrun_i && !dev_unavail_i && beyond_limit_i
    |=> fault_o && fault_vec_o == VEC_GEN_PROT; endproperty
  a_gp: assert property (p_gp) else $error("bad protection vector");
  property p_norm; clean && denormal_i && op_i inside {OP_DIVIDE, OP_SQRT, OP_PREM, OP_TO_INT,
    OP_TO_DEC} |=> normalize_o && done_o; endproperty
  a_norm: assert property (p_norm) else $error("denormal not normalized");
  property p_env; issue_i && !seg_overrun_i && op_i == OP_ENV_LOAD
    && !(env_first_ok_i && env_last_ok_i)
    |=> !env_commit_o && fault_o; endproperty
  a_env: assert property (p_env) else $error("env load committed");
  property p_err_now; complete_i && unmasked_exc_i && !defer_q |-> ##[1:2] fp_error_out_o;
  endproperty
  a_err_now: assert property (p_err_now) else $error("error pin late");
  property p_err_late; issue_i && pend_q && defer_q |-> ##[1:2] fp_error_out_o; endproperty
  a_err_late: assert property (p_err_late) else $error("deferred pin late");
endmodule : fpexc_unit_properties
bind fpexc_unit fpexc_unit_properties u_props (.*);
`default_nettype wire

// file: verif/fpexc_unit_tb_top.sv
/*
  testbench of fpexc_unit: table of plain instructions, then faults,
  indefinite values and the error pin. assumes the irq model and checker.
*/
`timescale 1ns/10ps
`default_nettype none
module fpexc_unit_tb_top;
  import fpexc_pkg::*;
  typedef struct packed {fpexc_op_e op; logic [10:0] f; logic [2:0] q; logic [2:0] c;
    logic [14:0] e; logic [9:0] x;} fpexc_row_s;
  logic clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, issue_i = 0;
  logic denormal_i = 0, misaligned_i = 0, stack_part_i = 0, v86_i = 0, dev_unavail_i = 0;
  logic seg_overrun_i = 0, beyond_limit_i = 0, env_first_ok_i = 0, env_last_ok_i = 0;
  logic stack_overflow_i = 0, invalid_masked_i = 0, snan_i = 0, underflow_i = 0, inexact_i = 0;
  logic uflow_loss_i = 0, cmp_less_i = 0, cmp_equal_i = 0, cmp_unord_i = 0, top_zero_i = 0;
  logic next_zero_i = 0, complete_i = 0, unmasked_exc_i = 0, handled_i = 0, er, irq;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, rd;
  logic [1:0] cpl_i = 2'h3;
  logic [2:0] quotient_i = 0;
  logic [14:0] top_exp_i = 0, next_exp_i = 0;
  fpexc_op_e op_i = OP_ARITH;
  logic pready_o, pslverr_o, fp_error_out_o, done_o, fault_o, abort_o, normalize_o, invalid_o;
  logic underflow_o, precision_o, range_err_o, scale_keep_o, round_nearest_o, env_commit_o;
  logic cond_we_o;
  logic [7:0] fault_vec_o;
  logic [1:0] indef_o;
  logic [3:0] cond_o;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  fpexc_op_e io [3] = '{OP_ARITH, OP_TO_INT, OP_TO_DEC};
  // flags {den,mis,stp,dev,seg,bey,sov,imk,inx,first,last}; x {done,norm,rng,keep,prec,we,cond}
  fpexc_row_s rows [15] = '{'{OP_DIVIDE, 11'h403, 0, 0, 15'h3fff, 10'h300},
    '{OP_SQRT, 11'h403, 0, 0, 15'h3fff, 10'h300}, '{OP_PREM, 11'h003, 5, 0, 0, 10'h213},
    '{OP_IEEE_REM, 11'h003, 6, 0, 0, 10'h219}, '{OP_UCOM, 11'h003, 0, 4, 0, 10'h21d},
    '{OP_UCOM_POP, 11'h003, 0, 2, 0, 10'h218}, '{OP_UCOM_POP2, 11'h003, 0, 1, 0, 10'h211},
    '{OP_TAN, 11'h003, 0, 0, 15'h403d, 10'h201}, '{OP_SINE, 11'h003, 0, 0, 15'h403e, 10'h281},
    '{OP_COSINE, 11'h003, 0, 0, 15'h403e, 10'h281}, '{OP_SINCOS, 11'h003, 0, 0, 0, 10'h201},
    '{OP_ATAN, 11'h003, 0, 0, 15'h403e, 10'h201}, '{OP_EXP2M1, 11'h003, 0, 0, 15'h3ffe, 10'h201},
    '{OP_EXP2M1, 11'h003, 0, 0, 15'h3fff, 10'h281}, '{OP_SCALE, 11'h007, 0, 0, 15'h3ffe, 10'h261}};
  fpexc_unit dut (.*);
  fpexc_irq_ctrl #(.LAT(2)) irq_ctrl (.clock_i, .rst_n_i, .fp_error_out_i(fp_error_out_o),
    .maskable_interrupt_in_o(irq));
  // 200 MHz core clock
  always #2.5 clock_i = ~clock_i;
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // apb master; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task automatic go(input fpexc_op_e o, input logic [10:0] f, input logic [2:0] q, c,
    input logic [14:0] e);
    @(posedge clock_i);
    op_i <= o;
    issue_i <= 1;
    {denormal_i, misaligned_i, stack_part_i, dev_unavail_i, seg_overrun_i, beyond_limit_i,
      stack_overflow_i, invalid_masked_i, inexact_i, env_first_ok_i, env_last_ok_i} <= f;
    quotient_i <= q;
    {cmp_unord_i, cmp_equal_i, cmp_less_i} <= c;
    top_exp_i <= e;
    next_exp_i <= e;
    @(posedge clock_i);
    issue_i <= 0;
    #1;
  endtask : go
  // one issue, then {commit,abort,fault,done,vector}
  task automatic ft(input fpexc_op_e o, input logic [10:0] f, input logic [11:0] x);
    go(o, f, 0, 0, 0);
    chk({env_commit_o, abort_o, fault_o, done_o, fault_vec_o}, x);
  endtask : ft
  // one cycle of {complete, unmasked, handled} from the low three bits
  task automatic raise(input logic [31:0] a);
    @(posedge clock_i);
    {complete_i, unmasked_exc_i, handled_i} <= a[2:0];
    @(posedge clock_i);
    {complete_i, unmasked_exc_i, handled_i} <= 3'h0;
  endtask : raise
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1;
    #1;
    chk({fp_error_out_o, done_o, fault_o, abort_o}, 0);
    apb(0, 32'h0000_0000, 0);
    chk(rd, 32'h0000_1000);
    apb(0, 32'h0000_0010, 0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].f, rows[i].q, rows[i].c, rows[i].e);
      chk({done_o, normalize_o, range_err_o, scale_keep_o, precision_o, cond_we_o, cond_o},
        rows[i].x);
    end
    @(posedge clock_i);
    snan_i <= 1;
    underflow_i <= 1;
    uflow_loss_i <= 1;
    go(OP_IEEE_REM, 11'h003, 0, 0, 0);
    chk({round_nearest_o, invalid_o, underflow_o}, 3'b101);
    go(OP_UCOM, 11'h003, 0, 3'h4, 0);
    chk({round_nearest_o, invalid_o, underflow_o}, 3'b010);
    go(OP_PREM, 11'h003, 0, 0, 0);
    chk({round_nearest_o, invalid_o, underflow_o}, 3'b001);
    go(OP_SCALE, 11'h003, 0, 0, 15'h3fff);
    chk({scale_keep_o, precision_o}, 2'b01);
    @(posedge clock_i);
    snan_i <= 0;
    underflow_i <= 0;
    uflow_loss_i <= 0;
    $display("test table done");
    apb(1, 32'h0000_0000, 32'h0000_2002);
    apb(0, 32'h0000_0000, 0);
    chk(rd, 32'h0000_2002);
    ft(OP_ARITH, 11'h0c3, 12'h400);
    ft(OP_ARITH, 11'h083, 12'h207);
    ft(OP_ARITH, 11'h023, 12'h20d);
    ft(OP_ARITH, 11'h203, 12'h211);
    ft(OP_STATE_SAVE, 11'h303, 12'h100);
    ft(OP_ENV_LOAD, 11'h002, 12'h20b);
    ft(OP_ENV_LOAD, 11'h003, 12'h900);
    foreach (io[i]) begin
      go(io[i], 11'h01b, 0, 0, 0);
      chk(indef_o, i + 1);
    end
    $display("test faults done");
    raise(6);
    repeat (2) @(posedge clock_i);
    #1;
    chk(fp_error_out_o, 1);
    repeat (3) @(posedge clock_i);
    #1;
    chk(irq, 1);
    ft(OP_ARITH, 11'h003, 12'h210);
    @(posedge clock_i);
    v86_i <= 1;
    ft(OP_ARITH, 11'h003, 12'h220);
    @(posedge clock_i);
    v86_i <= 0;
    raise(1);
    apb(1, 32'h0000_0000, 32'h0000_1003);
    raise(6);
    repeat (3) @(posedge clock_i);
    #1;
    chk(fp_error_out_o, 0);
    ft(OP_ARITH, 11'h003, 12'h210);
    repeat (2) @(posedge clock_i);
    #1;
    chk(fp_error_out_o, 1);
    apb(1, 32'h0000_0004, 1);
    apb(0, 32'h0000_0004, 0);
    chk(rd, 32'h0000_1000);
    chk(fp_error_out_o, 0);
    apb(0, 32'h0000_0008, 0);
    chk(rd, 32'h0000_0007);
    $display("test error pin done");
    @(posedge clock_i);
    rst_n_i <= 0;
    @(posedge clock_i);
    rst_n_i <= 1;
    apb(0, 32'h0000_0008, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 32'h0000_0000, 0);
    chk(rd, 32'h0000_1000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : fpexc_unit_tb_top
`default_nettype wire
